/* logic/sac_pkg.sv */
/*
 * Constants, types and register map of the SAR converter control block.
 * Assumes a 125 MHz system clock and an APB master with 32-bit data.
 */
// Functional notes
// - A 12-bit successive-approximation result is written to the result registers.
// - Every input channel passes one mux into one sample-and-hold stage.
// - The channel register picks the input sampled for the next conversion.
// - Select bit 1 clocks from the RC oscillator; 0 from system clock.
// - System-clock source is divided by the programmed divider ratio.
// - Codes 0,1,2,3,7,15,63 divide by 2,4,6,8,16,32,128.
// - One converter clock period per result bit, plus overhead.
// - Divided clock follows system clock frequency; RC source does not.
// - Control runs on the selected clock; RC adds a synchronisation delay.
// - In Sleep only the RC source runs conversions.
// - The selected pin is sampled whatever its analog-select bit says.
// - Separate requests for conversion complete and threshold match.
// - Both requests can wake the device from Sleep.
// - Positive and negative reference selects choose the references.
// - Current and previous result registers are kept.
// - Double-sample mode runs two back-to-back conversions automatically.
// - A programmable capacitor array adds sample-and-hold capacitance.
// - Guard-ring digital outputs are driven for capacitive sensing.
// - Averaging and low-pass filtering of results are provided.
// - Completion of the final conversion clears the go bit unless continuous mode is set.

package sac_pkg;
    // ==========================================================
    // register offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CHAN = 12'h004;
    localparam logic [11:0] OFS_CLKDIV = 12'h008;
    localparam logic [11:0] OFS_REF = 12'h00C;
    localparam logic [11:0] OFS_CAP = 12'h010;
    localparam logic [11:0] OFS_TIME = 12'h014;
    localparam logic [11:0] OFS_RES = 12'h018;
    localparam logic [11:0] OFS_PREV = 12'h01C;
    localparam logic [11:0] OFS_FILT = 12'h020;
    localparam logic [11:0] OFS_THLO = 12'h024;
    localparam logic [11:0] OFS_THHI = 12'h028;
    localparam logic [11:0] OFS_STAT = 12'h02C;
    // ==========================================================
    // control, status, reference and timing field positions
    localparam int CTRL_ON = 0;
    localparam int CTRL_GO = 1;
    localparam int CTRL_CS = 2;
    localparam int CTRL_CONTINUOUS_MODE_FLAG = 3;
    localparam int CTRL_DSEN = 4;
    localparam int CTRL_MODE = 5;
    localparam int CTRL_GPOL = 7;
    localparam int STAT_DONE = 0;
    localparam int STAT_THR = 1;
    localparam int STAT_BUSY = 2;
    localparam int REF_NEGATIVE_REF_SEL = 4;
    localparam int TIME_PRE = 8;
    // ==========================================================
    // reset values and widths
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [5:0] CHAN_RST = 6'h00;
    localparam logic [5:0] CLKDIV_RST = 6'h00;
    localparam logic [11:0] THHI_RST = 12'hFFF;
    localparam logic [11:0] SAR_MSB = 12'h800;
    localparam logic [3:0] SAR_TOP = 4'hB;
    localparam logic [4:0] SAR_BITS = 5'h0C;
    // ==========================================================
    // computation modes
    localparam logic [1:0] MODE_BASIC = 2'h0;
    localparam logic [1:0] MODE_AVG = 2'h1;
    localparam logic [1:0] MODE_LPF = 2'h2;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_PRE = 5'h02,
        ST_ACQ = 5'h04,
        ST_CONV = 5'h08,
        ST_DONE = 5'h10
    } sac_state_e;

    typedef struct packed
    {
        logic [5:0] chan;
        logic [1:0] positive_ref_sel;
        logic negative_ref_sel;
        logic [4:0] cap;
        logic sample;
        logic [11:0] dac;
        logic guard_a;
        logic guard_b;
    } sac_analog_s;
endpackage

/* logic/sac_top.sv */
/*
 * SAR converter control: APB registers, clock source and divider,
 * precharge/acquisition/conversion sequencing, results and computation.
 * Assumes an analog comparator whose output is high when the held input
 * is at or above the trial code, and a free-running RC oscillator pin.
 */
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module sac_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rc_osc_in,
    input wire logic cmp_in,
    input wire logic sleep,
    output var sac_pkg::sac_analog_s analog,
    output logic conv_done_flag,
    output logic thresh_flag,
    output logic wake_req,
    output logic busy
);
    // ==========================================================
    // apb decode
    logic [7:0] ctrl;
    logic [5:0] chan_reg;
    logic [5:0] clkdiv;
    logic [4:0] refsel;
    logic [4:0] cap;
    logic [15:0] times;
    logic [11:0] res;
    logic [11:0] prev;
    logic [11:0] filt;
    logic [11:0] thlo;
    logic [11:0] thhi;
    logic [31:0] rd_mux;
    logic rd_err;
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite;
    wire wr_ctrl = wr && paddr == sac_pkg::OFS_CTRL;
    wire wr_div = wr && paddr == sac_pkg::OFS_CLKDIV;
    wire wr_stat = wr && paddr == sac_pkg::OFS_STAT;
    assign pready = 1'b1;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            sac_pkg::OFS_CTRL: rd_mux = {24'h0, ctrl};
            sac_pkg::OFS_CHAN: rd_mux = {26'h0, chan_reg};
            sac_pkg::OFS_CLKDIV: rd_mux = {26'h0, clkdiv};
            sac_pkg::OFS_REF: rd_mux = {27'h0, refsel};
            sac_pkg::OFS_CAP: rd_mux = {27'h0, cap};
            sac_pkg::OFS_TIME: rd_mux = {16'h0, times};
            sac_pkg::OFS_RES: rd_mux = {20'h0, res};
            sac_pkg::OFS_PREV: rd_mux = {20'h0, prev};
            sac_pkg::OFS_FILT: rd_mux = {20'h0, filt};
            sac_pkg::OFS_THLO: rd_mux = {20'h0, thlo};
            sac_pkg::OFS_THHI: rd_mux = {20'h0, thhi};
            sac_pkg::OFS_STAT: rd_mux = {29'h0, busy, thresh_flag, conv_done_flag};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= rd_err;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            chan_reg <= sac_pkg::CHAN_RST;
            clkdiv <= sac_pkg::CLKDIV_RST;
            refsel <= 5'h00;
            cap <= 5'h00;
            times <= 16'h0000;
            thlo <= 12'h000;
            thhi <= sac_pkg::THHI_RST;
        end
        else if (wr)
        begin
            case (paddr)
                sac_pkg::OFS_CHAN: chan_reg <= pwdata[5:0];
                sac_pkg::OFS_CLKDIV: clkdiv <= pwdata[5:0];
                sac_pkg::OFS_REF: refsel <= pwdata[4:0];
                sac_pkg::OFS_CAP: cap <= pwdata[4:0];
                sac_pkg::OFS_TIME: times <= pwdata[15:0];
                sac_pkg::OFS_THLO: thlo <= pwdata[11:0];
                sac_pkg::OFS_THHI: thhi <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // conversion clock source
    logic [6:0] div_cnt;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic cmp_s1;
    logic cmp_s;
    wire [6:0] div_lim = {clkdiv, 1'b1};
    wire div_tick = div_cnt >= div_lim;
    wire rc_edge = rc_s2 && !rc_s3;
    wire cs = ctrl[sac_pkg::CTRL_CS];
    // divided clock halts in sleep; rc keeps running
    wire tick = cs ? rc_edge : (div_tick && !sleep);

    always_ff @(posedge clk)
    begin
        if (!resetn || div_tick)
            div_cnt <= 7'h00;
        else
            div_cnt <= div_cnt + 7'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
            cmp_s1 <= 1'b0;
            cmp_s <= 1'b0;
        end
        else
        begin
            rc_s1 <= rc_osc_in;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
            cmp_s1 <= cmp_in;
            cmp_s <= cmp_s1;
        end
    end

    // ==========================================================
    // sequencer
    sac_pkg::sac_state_e state;
    sac_pkg::sac_state_e next_state;
    logic [7:0] tcnt;
    logic [3:0] idx;
    logic [11:0] sar;
    logic [5:0] chan_lat;
    logic pass;
    wire on = ctrl[sac_pkg::CTRL_ON];
    wire go = ctrl[sac_pkg::CTRL_GO];
    wire continuous_mode_flag = ctrl[sac_pkg::CTRL_CONTINUOUS_MODE_FLAG];
    wire dsen = ctrl[sac_pkg::CTRL_DSEN];
    wire abort = !go || !on;
    wire fin = tick && state == sac_pkg::ST_DONE;
    wire last = !dsen || pass;
    wire again = fin && (!last || continuous_mode_flag);

    always_comb
    begin
        next_state = state;
        case (state)
            sac_pkg::ST_IDLE:
                if (go && on && tick)
                    next_state = sac_pkg::ST_PRE;
            sac_pkg::ST_PRE:
                if (tick && tcnt == 8'h00)
                    next_state = sac_pkg::ST_ACQ;
            sac_pkg::ST_ACQ:
                if (tick && tcnt == 8'h00)
                    next_state = sac_pkg::ST_CONV;
            sac_pkg::ST_CONV:
                if (tick && idx == 4'h0)
                    next_state = sac_pkg::ST_DONE;
            sac_pkg::ST_DONE:
                if (tick)
                    next_state = again ? sac_pkg::ST_PRE : sac_pkg::ST_IDLE;
            default: next_state = sac_pkg::ST_IDLE;
        endcase
        if (abort && state != sac_pkg::ST_IDLE)
            next_state = sac_pkg::ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state <= sac_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tcnt <= 8'h00;
            idx <= 4'h0;
            sar <= 12'h000;
            chan_lat <= 6'h00;
            pass <= 1'b0;
        end
        else if (tick)
        begin
            case (state)
                sac_pkg::ST_IDLE:
                begin
                    tcnt <= times[sac_pkg::TIME_PRE +: 8];
                    chan_lat <= chan_reg;
                    pass <= 1'b0;
                end
                sac_pkg::ST_PRE, sac_pkg::ST_ACQ:
                begin
                    tcnt <= tcnt - 8'h01;
                    if (tcnt == 8'h00)
                        tcnt <= times[7:0];
                    sar <= sac_pkg::SAR_MSB;
                    idx <= sac_pkg::SAR_TOP;
                end
                sac_pkg::ST_CONV:
                begin
                    sar[idx] <= cmp_s;
                    if (idx != 4'h0)
                    begin
                        sar[idx - 4'h1] <= 1'b1;
                        idx <= idx - 4'h1;
                    end
                end
                sac_pkg::ST_DONE:
                begin
                    tcnt <= times[sac_pkg::TIME_PRE +: 8];
                    pass <= !last;
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // results and computation
    logic [12:0] avg_sum;
    logic [13:0] lpf_diff;
    logic [11:0] next_filt;
    assign avg_sum = {1'b0, sar} + {1'b0, res};
    assign lpf_diff = {2'b00, sar} - {2'b00, filt};
    wire [13:0] lpf_step = 14'($signed(lpf_diff) >>> 2);
    wire [1:0] mode = ctrl[sac_pkg::CTRL_MODE +: 2];
    assign next_filt = mode == sac_pkg::MODE_AVG ? avg_sum[12:1] :
                       mode == sac_pkg::MODE_LPF ? filt + lpf_step[11:0] : sar;
    wire thr_hit = next_filt < thlo || next_filt > thhi;
    wire set_done = fin;
    wire set_thr = fin && last && thr_hit;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            res <= 12'h000;
            prev <= 12'h000;
            filt <= 12'h000;
        end
        else if (fin)
        begin
            prev <= res;
            res <= sar;
            filt <= next_filt;
        end
    end

    // hardware set wins over a write-one clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            conv_done_flag <= 1'b0;
            thresh_flag <= 1'b0;
        end
        else
        begin
            conv_done_flag <= set_done ||
                (conv_done_flag && !(wr_stat && pwdata[sac_pkg::STAT_DONE]));
            thresh_flag <= set_thr ||
                (thresh_flag && !(wr_stat && pwdata[sac_pkg::STAT_THR]));
        end
    end

    // go: software sets, completion of the final conversion clears unless continuous
    wire hw_clr_go = fin && last && !continuous_mode_flag;
    always_ff @(posedge clk)
    begin
        if (!resetn)
            ctrl <= sac_pkg::CTRL_RST;
        else if (wr_ctrl)
            ctrl <= pwdata[7:0];
        else if (hw_clr_go)
            ctrl[sac_pkg::CTRL_GO] <= 1'b0;
    end

    assign busy = state != sac_pkg::ST_IDLE;
    assign wake_req = sleep && (conv_done_flag || thresh_flag);

    // ==========================================================
    // analog controls
    wire track = state == sac_pkg::ST_PRE || state == sac_pkg::ST_ACQ;
    wire gpol = ctrl[sac_pkg::CTRL_GPOL] ^ pass;
    always_ff @(posedge clk)
    begin
        if (!resetn)
            analog <= '0;
        else
        begin
            // pin analog-select has no say in the mux
            analog.chan <= busy ? chan_lat : chan_reg;
            analog.positive_ref_sel <= refsel[1:0];
            analog.negative_ref_sel <= refsel[sac_pkg::REF_NEGATIVE_REF_SEL];
            analog.cap <= cap;
            analog.sample <= track;
            analog.dac <= sar;
            analog.guard_a <= track && gpol;
            analog.guard_b <= track && !gpol;
        end
    end

    // ==========================================================
    // checks
    logic [4:0] bit_cnt;
    always_ff @(posedge clk)
    begin
        if (!resetn || state != sac_pkg::ST_CONV)
            bit_cnt <= 5'h00;
        else if (tick)
            bit_cnt <= bit_cnt + 5'h01;
    end

    sequence s_finish;
        fin && last && !continuous_mode_flag && !wr_ctrl;
    endsequence
    sequence s_div_two;
        !div_tick ##1 (div_tick || $past(wr_div));
    endsequence

    property p_go_clear;
        @(posedge clk) disable iff (!resetn) s_finish |=> !go;
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("go not cleared");
    property p_done_flag;
        @(posedge clk) disable iff (!resetn) fin |=> conv_done_flag && res == $past(sar);
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag missing");
    property p_prev;
        @(posedge clk) disable iff (!resetn) fin |=> prev == $past(res);
    endproperty
    a_prev: assert property (p_prev) else $error("previous result lost");
    property p_div0;
        @(posedge clk) disable iff (!resetn)
            div_tick && clkdiv == 6'h00 && !wr_div |=> s_div_two;
    endproperty
    a_div0: assert property (p_div0) else $error("divide by 2 wrong");
    property p_sleep;
        @(posedge clk) disable iff (!resetn) sleep && !cs |-> !tick;
    endproperty
    a_sleep: assert property (p_sleep) else $error("divided clock ran in sleep");
    property p_bits;
        @(posedge clk) disable iff (!resetn)
            state == sac_pkg::ST_CONV && next_state == sac_pkg::ST_DONE |=>
            bit_cnt == sac_pkg::SAR_BITS;
    endproperty
    a_bits: assert property (p_bits) else $error("bit count not 12");
    property p_thr;
        @(posedge clk) disable iff (!resetn)
            set_thr |=> thresh_flag ##1 (thresh_flag || $past(wr_stat));
    endproperty
    a_thr: assert property (p_thr) else $error("threshold flag lost");
    property p_wake;
        @(posedge clk) disable iff (!resetn) sleep && $rose(conv_done_flag) |-> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake request");
    property p_chan;
        @(posedge clk) disable iff (!resetn)
            $rose(busy) |=> analog.chan == chan_lat && chan_lat == $past(chan_reg, 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not latched");
endmodule

`default_nettype wire

/* test/sac_analog_model.sv */
/*
 * Behavioural model of the analog side: track-and-hold, comparator and RC oscillator.
 * Assumes the converter control drives the sac_analog_s struct on clk.
 */
`timescale 1ns/100ps
`default_nettype none

module sac_analog_model (
    input wire logic clk,
    input wire sac_pkg::sac_analog_s analog,
    output logic cmp_in,
    output logic rc_osc_in
);
    logic [11:0] held;

    // free-running rc source, phase unrelated to clk
    initial
    begin
        held = 12'hA5A;
        rc_osc_in = 1'b0;
        forever #27.3 rc_osc_in = ~rc_osc_in;
    end

    // each channel carries a level made from its own number
    always @(posedge clk)
    begin
        if (analog.sample)
            held <= {analog.chan, analog.chan};
    end

    // keep the trial bit while the held level is at or above it
    assign cmp_in = (held >= analog.dac);
endmodule

`default_nettype wire

/* test/sac_top_tb.sv */
/*
 * Self-checking bench of the converter control over APB, with the analog model.
 * Assumes a zero-wait APB slave; pre/acq times are set by the scenarios.
 */
`timescale 1ns/100ps
`default_nettype none

module sac_top_tb;
    typedef struct packed
    {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic e;
    } sac_note_s;

    logic clk, resetn, psel, penable, pwrite, pready, pslverr, rc_osc_in, cmp_in, sleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    sac_pkg::sac_analog_s analog;
    logic conv_done_flag, thresh_flag, wake_req, busy;
    int fail_count, n_tests, n, i, nd;
    logic [15:0] lfsr_q;
    logic [5:0] ch;
    logic [11:0] exp_res, old_res;
    logic [5:0] codes [8] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h07, 6'h0F, 6'h3F, 6'h00};
    sac_note_s notes [$];
    sac_note_s nt;

    sac_top dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_osc_in(rc_osc_in), .cmp_in(cmp_in), .sleep(sleep),
        .analog(analog), .conv_done_flag(conv_done_flag), .thresh_flag(thresh_flag),
        .wake_req(wake_req), .busy(busy));

    sac_analog_model model_u (.clk(clk), .analog(analog), .cmp_in(cmp_in),
        .rc_osc_in(rc_osc_in));

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // lets registered outputs settle after the write edge
    task automatic settle();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic e);
        notes.push_back('{a, d, m, e});
        apb(1'b0, a, 32'h0);
    endtask

    // start a conversion and count clk cycles up to the done flag
    task automatic conv(input logic [5:0] c, input logic [7:0] ctrl);
        apb(1'b1, sac_pkg::OFS_CHAN, {26'h0, c});
        settle();
        check("analog chan", {26'h0, c}, {26'h0, analog.chan});
        apb(1'b1, sac_pkg::OFS_CTRL, {24'h0, ctrl});
        n = 0;
        while (conv_done_flag !== 1'b1 && n < 6000)
        begin
            @(posedge clk);
            n++;
        end
        check("conv done", 32'h1, {31'h0, conv_done_flag});
    endtask

    always @(posedge clk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            nt = notes.pop_front();
            check($sformatf("read %h", nt.a), nt.d, prdata & nt.m);
            check($sformatf("pslverr %h", nt.a), {31'h0, nt.e}, {31'h0, pslverr});
        end
        if (analog.sample === 1'b1)
            check("guard", 32'h1, {31'h0, analog.guard_a ^ analog.guard_b});
    end

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #(8 * 60000);
        fail_count++;
        close_out();
    end

    // ==========================================================
    // scenarios
    initial
    begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sleep = 1'b0;
        fail_count = 0;
        n_tests = 0;
        lfsr_q = 16'h000F;
        exp_res = 12'h000;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd(sac_pkg::OFS_CTRL, 32'h0, '1, 1'b0);
        rd(sac_pkg::OFS_CLKDIV, 32'h0, '1, 1'b0);
        rd(sac_pkg::OFS_THHI, 32'hFFF, '1, 1'b0);
        rd(sac_pkg::OFS_STAT, 32'h0, '1, 1'b0);
        rd(12'h030, 32'h0, 32'h0, 1'b1);
        apb(1'b1, sac_pkg::OFS_REF, 32'h12);
        settle();
        check("positive_ref_sel negative_ref_sel", 32'h5, {29'h0, analog.positive_ref_sel, analog.negative_ref_sel});
        apb(1'b1, sac_pkg::OFS_CAP, 32'h15);
        settle();
        check("cap", 32'h15, {27'h0, analog.cap});
        // precharge 2, acquisition 1: ticks per conversion 1+3+2+12+1 = 19
        apb(1'b1, sac_pkg::OFS_TIME, 32'h0201);
        // eight divider codes, random channels
        for (i = 0; i < 8; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            ch = lfsr_q[5:0] | 6'h01;
            nd = 2 * (codes[i] + 1);
            old_res = exp_res;
            exp_res = {ch, ch};
            apb(1'b1, sac_pkg::OFS_CLKDIV, {26'h0, codes[i]});
            conv(ch, 8'h03);
            check("conv cycles", 32'h1, {31'h0, n >= 18 * nd && n <= 19 * nd + 4});
            if (codes[i] != 6'h00)
            begin
                rd(sac_pkg::OFS_RES, {20'h0, exp_res}, '1, 1'b0);
                rd(sac_pkg::OFS_PREV, {20'h0, old_res}, '1, 1'b0);
            end
            rd(sac_pkg::OFS_CTRL, 32'h1, 32'hFF, 1'b0);
            apb(1'b1, sac_pkg::OFS_STAT, 32'h3);
        end
        // rc source ignores the slow divider
        apb(1'b1, sac_pkg::OFS_CLKDIV, 32'h3F);
        conv(6'h2A, 8'h07);
        check("rc cycles", 32'h1, {31'h0, n < 400});
        rd(sac_pkg::OFS_RES, 32'hAAA, '1, 1'b0);
        apb(1'b1, sac_pkg::OFS_STAT, 32'h3);
        // asleep: divided clock stalls, rc runs and wakes
        sleep <= 1'b1;
        apb(1'b1, sac_pkg::OFS_CLKDIV, 32'h0);
        apb(1'b1, sac_pkg::OFS_CTRL, 32'h3);
        repeat (200) @(posedge clk);
        check("sleep busy", 32'h0, {30'h0, busy, conv_done_flag});
        conv(6'h2A, 8'h07);
        check("wake", 32'h1, {31'h0, wake_req});
        sleep <= 1'b0;
        apb(1'b1, sac_pkg::OFS_STAT, 32'h3);
        // threshold below low level, then averaging
        apb(1'b1, sac_pkg::OFS_CLKDIV, 32'h3);
        apb(1'b1, sac_pkg::OFS_THLO, 32'h800);
        conv(6'h01, 8'h03);
        repeat (2) @(posedge clk);
        check("thresh", 32'h1, {31'h0, thresh_flag});
        apb(1'b1, sac_pkg::OFS_STAT, 32'h3);
        apb(1'b1, sac_pkg::OFS_THLO, 32'h0);
        conv(6'h3E, 8'h23);
        rd(sac_pkg::OFS_FILT, 32'h7FF, '1, 1'b0);
        apb(1'b1, sac_pkg::OFS_STAT, 32'h3);
        // continuous keeps go, then abort
        conv(6'h05, 8'h0B);
        rd(sac_pkg::OFS_CTRL, 32'h0B, 32'hFF, 1'b0);
        apb(1'b1, sac_pkg::OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        check("abort busy", 32'h0, {31'h0, busy});
        apb(1'b1, sac_pkg::OFS_STAT, 32'h3);
        // double sample: go survives the first of two
        apb(1'b1, sac_pkg::OFS_CLKDIV, 32'hF);
        conv(6'h09, 8'h13);
        rd(sac_pkg::OFS_CTRL, 32'h13, 32'hFF, 1'b0);
        n = 0;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        check("dsen second", 32'h1, {31'h0, n > 300 && n < 2000});
        rd(sac_pkg::OFS_CTRL, 32'h11, 32'hFF, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
